// ===== capture_compare_pkg.sv
// constants and types shared by the timer capture/compare unit
// Functional notes
// - each new capture overwrites the capture register, read or not.
// - timer 0 source 00 instant conversion done, 01 accumulated; 10/11 reserved.
// - timer 1 source 00 port pin, 01 lin rx done, 10 lin tx done.
// - an internal source event also raises its own request, untouched here.
// - writing one clears the capture flag; software clears after polarity change.
// - counter compared with both compare registers; flag set on next tick.
// - 8-bit width sets flag a or b; 16-bit width sets only a.
// - compare flag interrupts when enabled; cleared by service or write one.
// - counter write suppresses all compare matches in the next tick.
// - all logic on system clock; tick is only a one-cycle enable.
// - capture edge copies counter and sets flag in the same cycle.
// - edge polarity zero triggers on falling, one on rising edge.
// - filter output changes after four equal samples, five cycles delay.
package capture_compare_pkg;

    // ********
    // register map, byte addresses
    // ********
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_COUNTER = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CMP_A = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CMP_B = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_CAPTURE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h18;

    // ********
    // widths and field layouts
    // ********
    localparam int CNT_W = 16;
    localparam int CMP_W = 8;
    localparam int CTRL_W = 6;
    localparam int FLAG_W = 3;
    localparam int FILTER_SAMPLES = 4;

    typedef struct packed {
        logic [1:0] capture_source_select;
        logic capture_edge_polarity;
        logic capture_filter_enable;
        logic capture_enable;
        logic width_select_16;
    } ctrl_t;

    typedef struct packed {
        logic compare_flag_b;
        logic compare_flag_a;
        logic capture_flag;
    } flags_t;

    // ********
    // source codes and reset values
    // ********
    localparam logic [1:0] SRC_T0_INSTANT = 2'h0;
    localparam logic [1:0] SRC_T0_ACCUM = 2'h1;
    localparam logic [1:0] SRC_T1_PIN = 2'h0;
    localparam logic [1:0] SRC_T1_RX = 2'h1;
    localparam logic [1:0] SRC_T1_TX = 2'h2;
    localparam ctrl_t CTRL_RST = 6'h00;
    localparam flags_t FLAGS_RST = 3'h0;
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [CMP_W-1:0] CMP_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== capture_conditioner.sv
// noise filter and edge detector for the selected capture source
`timescale 1ns/1ps
module capture_conditioner #(
    parameter int SAMPLES = capture_compare_pkg::FILTER_SAMPLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic level_in,
    input wire logic filter_en,
    input wire logic edge_rising,
    output logic trig
);

    // ********
    // sample history and filtered level
    // ********
    logic [SAMPLES-1:0] hist_ff;
    logic filt_ff;
    logic prev_ff;
    logic cond;
    wire all_high = &hist_ff;
    wire all_low = ~|hist_ff;

    // history shifts every system clock, prescaler has no say
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hist_ff <= '0;
            filt_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            hist_ff <= {hist_ff[SAMPLES-2:0], level_in};
            if (all_high) begin
                filt_ff <= 1'b1;
            end else if (all_low) begin
                filt_ff <= 1'b0;
            end
            prev_ff <= cond;
        end
    end

    // ********
    // edge detection
    // ********
    // bypass keeps the unfiltered path free of the extra delay
    assign cond = filter_en ? filt_ff : level_in;
    assign trig = edge_rising ? (cond & ~prev_ff) : (~cond & prev_ff);

endmodule // capture_conditioner

// ===== timer_capture_compare_unit.sv
// capture/compare unit of a timer with an axi4-lite register slave
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module timer_capture_compare_unit #(
    parameter int TIMER_INDEX = 0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [capture_compare_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [capture_compare_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic timer_tick,
    input wire logic src_instant_conv_done,
    input wire logic src_accum_conv_done,
    input wire logic port_b_bit7,
    input wire logic src_lin_rx_done,
    input wire logic src_lin_tx_done,
    input wire logic irq_ack_capture,
    input wire logic irq_ack_compare_a,
    input wire logic irq_ack_compare_b,
    output logic irq
);

    // ********
    // helpers
    // ********
    // merge written byte lanes into the old register word
    function automatic logic [31:0] apply_strb(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // hardware set wins over any clear in the same cycle
    function automatic capture_compare_pkg::flags_t flag_next(
        input capture_compare_pkg::flags_t cur,
        input capture_compare_pkg::flags_t set,
        input capture_compare_pkg::flags_t clr
    );
        return (cur & ~clr) | set;
    endfunction

    // word-aligned address for decoding
    function automatic logic [capture_compare_pkg::ADDR_W-1:0] word_addr(
        input logic [capture_compare_pkg::ADDR_W-1:0] a
    );
        return {a[capture_compare_pkg::ADDR_W-1:2], 2'h0};
    endfunction

    // ********
    // state
    // ********
    capture_compare_pkg::ctrl_t ctrl_ff;
    capture_compare_pkg::flags_t status_ff;
    capture_compare_pkg::flags_t mask_ff;
    logic [capture_compare_pkg::CNT_W-1:0] count_ff;
    logic [capture_compare_pkg::CMP_W-1:0] cmp_a_ff;
    logic [capture_compare_pkg::CMP_W-1:0] cmp_b_ff;
    logic [capture_compare_pkg::CNT_W-1:0] capture_ff;
    logic block_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [capture_compare_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic pin_s1_ff;
    logic pin_s2_ff;
    logic pin_s3_ff;
    logic src_port_pin_ff;

    // ********
    // axi4-lite write channel
    // ********
    // one write in flight: new address or data waits for bready
    assign awready = ~aw_held_ff & ~bvalid_ff;
    assign wready = ~w_held_ff & ~bvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;

    wire aw_hs = awvalid & awready;
    wire w_hs = wvalid & wready;
    wire do_write = aw_held_ff & w_held_ff;
    wire [capture_compare_pkg::ADDR_W-1:0] wr_addr = word_addr(awaddr_ff);

    // write decode
    wire wr_ctrl = do_write & (wr_addr == capture_compare_pkg::REG_CTRL);
    wire wr_counter = do_write & (wr_addr == capture_compare_pkg::REG_COUNTER);
    wire wr_cmp_a = do_write & (wr_addr == capture_compare_pkg::REG_CMP_A);
    wire wr_cmp_b = do_write & (wr_addr == capture_compare_pkg::REG_CMP_B);
    wire wr_capture = do_write & (wr_addr == capture_compare_pkg::REG_CAPTURE);
    wire wr_status = do_write & (wr_addr == capture_compare_pkg::REG_STATUS);
    wire wr_mask = do_write & (wr_addr == capture_compare_pkg::REG_MASK);
    // capture register is read only; writes to it are quietly accepted
    wire wr_hit = wr_ctrl | wr_counter | wr_cmp_a | wr_cmp_b | wr_capture |
                  wr_status | wr_mask;
    wire [31:0] wr_merged = apply_strb(32'h0000_0000, wdata_ff, wstrb_ff);

    // address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
            if (w_hs) begin
                w_held_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= capture_compare_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? capture_compare_pkg::RESP_OKAY
                               : capture_compare_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ********
    // control, compare and mask registers
    // ********
    wire [31:0] ctrl_word = apply_strb({26'h0, ctrl_ff}, wdata_ff, wstrb_ff);
    wire [31:0] cmp_a_word = apply_strb({24'h0, cmp_a_ff}, wdata_ff, wstrb_ff);
    wire [31:0] cmp_b_word = apply_strb({24'h0, cmp_b_ff}, wdata_ff, wstrb_ff);
    wire [31:0] mask_word = apply_strb({29'h0, mask_ff}, wdata_ff, wstrb_ff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= capture_compare_pkg::CTRL_RST;
            cmp_a_ff <= capture_compare_pkg::CMP_RST;
            cmp_b_ff <= capture_compare_pkg::CMP_RST;
            mask_ff <= capture_compare_pkg::FLAGS_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= ctrl_word[capture_compare_pkg::CTRL_W-1:0];
            end
            if (wr_cmp_a) begin
                cmp_a_ff <= cmp_a_word[capture_compare_pkg::CMP_W-1:0];
            end
            if (wr_cmp_b) begin
                cmp_b_ff <= cmp_b_word[capture_compare_pkg::CMP_W-1:0];
            end
            if (wr_mask) begin
                mask_ff <= mask_word[capture_compare_pkg::FLAG_W-1:0];
            end
        end
    end

    // ********
    // counter and compare match
    // ********
    // the tick is an enable only; every flop sees every aclk edge
    wire wide = ctrl_ff.width_select_16;
    wire [31:0] cnt_word = apply_strb({16'h0, count_ff}, wdata_ff, wstrb_ff);
    wire [capture_compare_pkg::CNT_W-1:0] cnt_inc = count_ff + 16'h0001;
    wire [capture_compare_pkg::CNT_W-1:0] nxt_count =
        wr_counter ? cnt_word[capture_compare_pkg::CNT_W-1:0] :
        !timer_tick ? count_ff :
        wide ? cnt_inc : {8'h00, cnt_inc[7:0]};

    // 16-bit width joins b (high) and a (low) into one compare unit
    wire match_a = wide ? (count_ff == {cmp_b_ff, cmp_a_ff})
                        : (count_ff[7:0] == cmp_a_ff);
    wire match_b = ~wide & (count_ff[7:0] == cmp_b_ff);
    // a blocked tick drops the match instead of deferring it
    wire set_cmp_a = timer_tick & match_a & ~block_ff;
    wire set_cmp_b = timer_tick & match_b & ~block_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= capture_compare_pkg::COUNT_RST;
            block_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            // block holds across a stopped timer until the next tick
            if (wr_counter) begin
                block_ff <= 1'b1;
            end else if (timer_tick) begin
                block_ff <= 1'b0;
            end
        end
    end

    // ********
    // capture source selection
    // ********
    // pin passes four flops; a level change counts when two agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_s3_ff <= 1'b0;
            src_port_pin_ff <= 1'b0;
        end else begin
            pin_s1_ff <= port_b_bit7;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            if (pin_s2_ff == pin_s3_ff) begin
                src_port_pin_ff <= pin_s3_ff;
            end
        end
    end

    wire [1:0] sel = ctrl_ff.capture_source_select;
    // internal events are only observed; their own requests stay intact
    wire t0_level = (sel == capture_compare_pkg::SRC_T0_INSTANT) ?
                        src_instant_conv_done :
                    (sel == capture_compare_pkg::SRC_T0_ACCUM) ?
                        src_accum_conv_done : 1'b0;
    wire t0_valid = (sel == capture_compare_pkg::SRC_T0_INSTANT) |
                    (sel == capture_compare_pkg::SRC_T0_ACCUM);
    wire t1_level = (sel == capture_compare_pkg::SRC_T1_PIN) ?
                        src_port_pin_ff :
                    (sel == capture_compare_pkg::SRC_T1_RX) ? src_lin_rx_done :
                    (sel == capture_compare_pkg::SRC_T1_TX) ?
                        src_lin_tx_done : 1'b0;
    wire t1_valid = (sel == capture_compare_pkg::SRC_T1_PIN) |
                    (sel == capture_compare_pkg::SRC_T1_RX) |
                    (sel == capture_compare_pkg::SRC_T1_TX);
    wire src_level = (TIMER_INDEX == 0) ? t0_level : t1_level;
    wire src_valid = (TIMER_INDEX == 0) ? t0_valid : t1_valid;
    logic src_trig;

    // filter on short internal pulses may hide them; software's call
    capture_conditioner #(
        .SAMPLES(capture_compare_pkg::FILTER_SAMPLES)
    ) u_cond (
        .aclk(aclk),
        .aresetn(aresetn),
        .level_in(src_level),
        .filter_en(ctrl_ff.capture_filter_enable),
        .edge_rising(ctrl_ff.capture_edge_polarity),
        .trig(src_trig)
    );

    // ********
    // capture register
    // ********
    // a reserved code never captures, even if the old source toggles
    wire cap_event = src_trig & src_valid & ctrl_ff.capture_enable;
    wire [capture_compare_pkg::CNT_W-1:0] cap_value =
        wide ? count_ff : {8'h00, count_ff[7:0]};

    // no guard for unread data: a late reader simply loses the old stamp
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_ff <= capture_compare_pkg::COUNT_RST;
        end else if (cap_event) begin
            capture_ff <= cap_value;
        end
    end

    // ********
    // status flags and interrupt
    // ********
    capture_compare_pkg::flags_t flag_set;
    capture_compare_pkg::flags_t flag_clr;
    capture_compare_pkg::flags_t w1c_bits;
    capture_compare_pkg::flags_t ack_bits;

    assign flag_set = {set_cmp_b, set_cmp_a, cap_event};
    assign w1c_bits = wr_status ? wr_merged[capture_compare_pkg::FLAG_W-1:0]
                                : capture_compare_pkg::FLAGS_RST;
    assign ack_bits = {irq_ack_compare_b, irq_ack_compare_a,
                       irq_ack_capture};
    assign flag_clr = w1c_bits | ack_bits;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= capture_compare_pkg::FLAGS_RST;
        end else begin
            status_ff <= flag_next(status_ff, flag_set, flag_clr);
        end
    end

    // level output, high while any enabled flag stands
    assign irq = |(status_ff & mask_ff);

    // ********
    // axi4-lite read channel
    // ********
    assign arready = ~rvalid_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;

    wire ar_hs = arvalid & arready;
    wire [capture_compare_pkg::ADDR_W-1:0] rd_addr = word_addr(araddr);
    wire rd_ctrl = rd_addr == capture_compare_pkg::REG_CTRL;
    wire rd_counter = rd_addr == capture_compare_pkg::REG_COUNTER;
    wire rd_cmp_a = rd_addr == capture_compare_pkg::REG_CMP_A;
    wire rd_cmp_b = rd_addr == capture_compare_pkg::REG_CMP_B;
    wire rd_capture = rd_addr == capture_compare_pkg::REG_CAPTURE;
    wire rd_status = rd_addr == capture_compare_pkg::REG_STATUS;
    wire rd_mask = rd_addr == capture_compare_pkg::REG_MASK;
    wire rd_hit = rd_ctrl | rd_counter | rd_cmp_a | rd_cmp_b | rd_capture |
                  rd_status | rd_mask;
    // reads have no side effect; unmapped words read zero
    wire [31:0] rd_word =
        rd_ctrl ? {26'h0, ctrl_ff} :
        rd_counter ? {16'h0, count_ff} :
        rd_cmp_a ? {24'h0, cmp_a_ff} :
        rd_cmp_b ? {24'h0, cmp_b_ff} :
        rd_capture ? {16'h0, capture_ff} :
        rd_status ? {29'h0, status_ff} :
        rd_mask ? {29'h0, mask_ff} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= capture_compare_pkg::RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? capture_compare_pkg::RESP_OKAY
                               : capture_compare_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule // timer_capture_compare_unit

// ===== timer_capture_compare_unit_props.sv
// checker of bus handshakes and interrupt causes at the unit's ports
`timescale 1ns/1ps
module tccu_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic timer_tick,
    input wire logic src_instant_conv_done,
    input wire logic src_accum_conv_done,
    input wire logic port_b_bit7,
    input wire logic src_lin_rx_done,
    input wire logic src_lin_tx_done,
    input wire logic irq_ack_capture,
    input wire logic irq_ack_compare_a,
    input wire logic irq_ack_compare_b,
    input wire logic irq
);
    // ********
    // source age and properties
    // ********
    logic [4:0] srcs_ff;
    logic [4:0] age_ff;
    logic [4:0] nxt_age;
    wire logic [4:0] srcs = {src_lin_tx_done, src_lin_rx_done,
        port_b_bit7, src_accum_conv_done, src_instant_conv_done};
    // saturates, so a long quiet spell never wraps into a false window
    assign nxt_age = (srcs != srcs_ff) ? 5'h00 :
        (age_ff == 5'h1f) ? age_ff : age_ff + 5'h01;
    always_ff @(posedge aclk) begin
        srcs_ff <= srcs;
        age_ff <= aresetn ? nxt_age : 5'h1f;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_taken;
        arvalid && arready;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##2 bvalid)
        else $error("write answer not two edges on");
    AST_WR_BLOCK: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    AST_WR_DONE: assert property (bvalid && bready |=>
        !bvalid && awready && wready) else $error("write answer stuck");
    AST_RD_ANSWER: assert property (s_rd_taken |=> rvalid)
        else $error("read answer late");
    AST_RD_BLOCK: assert property (rvalid |-> !arready)
        else $error("read taken while answer pending");
    AST_RD_DONE: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer stuck");
    // irq may only rise after a tick, a register write or a source change
    AST_IRQ_RISE: assert property ($rose(irq) |->
        $past(timer_tick) || bvalid || age_ff < 5'h10)
        else $error("irq rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq) |-> bvalid ||
        $past(irq_ack_capture || irq_ack_compare_a || irq_ack_compare_b))
        else $error("irq fell without cause");
    AST_RESET_QUIET: assert property ($rose(aresetn) |->
        !irq && !bvalid && !rvalid) else $error("not quiet after reset");
endmodule // tccu_props
bind timer_capture_compare_unit tccu_props chk (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .bready, .arvalid, .arready, .rvalid, .rready, .timer_tick,
    .src_instant_conv_done, .src_accum_conv_done, .port_b_bit7,
    .src_lin_rx_done, .src_lin_tx_done, .irq_ack_capture,
    .irq_ack_compare_a, .irq_ack_compare_b, .irq);

// ===== event_source_model.sv
// far-side model: converter and link done events, and the port pin
`timescale 1ns/1ps
module event_source_model (
    input wire logic aclk,
    output logic [4:0] src
);
    // ********
    // drive helpers
    // ********
    // bit order {tx done, rx done, pin, accum done, instant done}
    initial src = 5'h00;
    // a done event is a short pulse that is also its own request
    task automatic pulse(input int idx, input int len);
        @(posedge aclk);
        src[idx] <= 1'b1;
        repeat (len) @(posedge aclk);
        src[idx] <= 1'b0;
    endtask
    // the pin holds its level until told otherwise
    task automatic set_pin(input logic lvl);
        @(posedge aclk);
        src[2] <= lvl;
    endtask
endmodule // event_source_model

// ===== timer_capture_compare_unit_tb_top.sv
// self-checking bench for the timer capture/compare unit
`timescale 1ns/1ps
module timer_capture_compare_unit_tb_top;
    // ********
    // signals and design
    // ********
    localparam int AW = capture_compare_pkg::ADDR_W;
    localparam logic [AW-1:0] CTL = capture_compare_pkg::REG_CTRL;
    localparam logic [AW-1:0] CNT = capture_compare_pkg::REG_COUNTER;
    localparam logic [AW-1:0] CAP = capture_compare_pkg::REG_CAPTURE;
    localparam logic [AW-1:0] ST = capture_compare_pkg::REG_STATUS;
    localparam logic [AW-1:0] MSK = capture_compare_pkg::REG_MASK;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AW-1:0] awaddr = 8'h00;
    logic [AW-1:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic timer_tick = 1'b0;
    logic [2:0] ack = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [4:0] src;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    always #20 aclk = ~aclk;
    event_source_model src_m (.aclk(aclk), .src(src));
    timer_capture_compare_unit #(.TIMER_INDEX(1)) dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .timer_tick, .src_instant_conv_done(src[0]),
        .src_accum_conv_done(src[1]), .port_b_bit7(src[2]),
        .src_lin_rx_done(src[3]), .src_lin_tx_done(src[4]),
        .irq_ack_capture(ack[0]), .irq_ack_compare_a(ack[1]),
        .irq_ack_compare_b(ack[2]), .irq);
    // ********
    // shared tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // each channel drops valid at the rising edge that takes it
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
                      input logic [1:0] er = 2'h0);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!bvalid);
        chk(bresp, er);
        bready <= 1'b0;
    endtask
    task automatic rchk(input logic [AW-1:0] a, input logic [31:0] exp,
                        input logic [1:0] er = 2'h0);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        chk(rdata, exp);
        chk(rresp, er);
        rready <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge aclk);
            timer_tick <= 1'b1;
            @(posedge aclk);
            timer_tick <= 1'b0;
        end
    endtask
    // irq must be up, then drop once the flag is serviced
    task automatic ack_irq(input int i);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h1);
        @(posedge aclk);
        ack[i] <= 1'b1;
        @(posedge aclk);
        ack[i] <= 1'b0;
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0);
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_reset;
        rchk(CTL, 32'h0);
        rchk(CAP, 32'h0);
        rchk(8'h1c, 32'h0, capture_compare_pkg::RESP_SLVERR);
        wr(8'h1c, 32'h1, capture_compare_pkg::RESP_SLVERR);
    endtask
    task automatic t_compare;
        wr(capture_compare_pkg::REG_CMP_A, 32'h5);
        wr(capture_compare_pkg::REG_CMP_B, 32'h7);
        wr(CNT, 32'h5);
        ticks(1);
        rchk(ST, 32'h0);
        wr(CNT, 32'h6);
        ticks(2);
        rchk(ST, 32'h4);
        wr(MSK, 32'h4);
        ack_irq(2);
        wr(CTL, 32'h1);
        wr(CNT, 32'h706);
        ticks(2);
        rchk(ST, 32'h0);
        wr(CNT, 32'h704);
        ticks(2);
        rchk(ST, 32'h2);
        wr(ST, 32'h7);
        rchk(ST, 32'h0);
    endtask
    // every source fires each pass, only the selected one may capture
    task automatic t_sources;
        logic [15:0] exp_cap;
        exp_cap = 16'h0;
        for (int c = 0; c < 4; c++) begin
            wr(CTL, {26'h0, 2'(c), 4'hb});
            wr(CNT, 32'h100 + c);
            wr(ST, 32'h7);
            src_m.set_pin(1'b1);
            for (int i = 0; i < 5; i++) if (i != 2) src_m.pulse(i, 2);
            repeat (16) @(posedge aclk);
            if (c != 3) exp_cap = 16'h100 + 16'(c);
            rchk(ST, (c == 3) ? 32'h0 : 32'h1);
            rchk(CAP, {16'h0, exp_cap});
            src_m.set_pin(1'b0);
        end
    endtask
    task automatic t_edges;
        wr(CTL, 32'h3);
        wr(CNT, 32'h200);
        wr(ST, 32'h7);
        src_m.set_pin(1'b1);
        repeat (16) @(posedge aclk);
        rchk(ST, 32'h0);
        wr(CNT, 32'h300);
        src_m.set_pin(1'b0);
        repeat (16) @(posedge aclk);
        rchk(CAP, 32'h300);
        wr(MSK, 32'h1);
        ack_irq(0);
        wr(CNT, 32'h400);
        src_m.pulse(2, 12);
        repeat (16) @(posedge aclk);
        wr(CNT, 32'h500);
        src_m.pulse(2, 12);
        repeat (16) @(posedge aclk);
        rchk(CAP, 32'h500);
        wr(CTL, 32'h7);
        wr(ST, 32'h7);
        src_m.pulse(2, 2);
        repeat (16) @(posedge aclk);
        rchk(ST, 32'h0);
        src_m.pulse(2, 8);
        repeat (16) @(posedge aclk);
        rchk(ST, 32'h1);
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // the whole run needs some hundreds of cycles; a hang ends here
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_compare();
        t_sources();
        t_edges();
        close_out();
    end
endmodule // timer_capture_compare_unit_tb_top
